// ### rtl/dtp_regs.sv
// trip factor and main profile holding register bank of the drive
`timescale 1ns/100ps
`default_nettype none
module dtp_regs #(
  parameter logic [31:0] FREQ_LIMIT = dtp_pkg::FREQ_MAX,
  parameter logic [31:0] TIME_LIMIT = dtp_pkg::TIME_MAX
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // holding register access from the network side
  input wire dtp_pkg::dtp_reg_req_s reg_req_i,
  output dtp_pkg::dtp_reg_rsp_s reg_rsp_o,
  // drive side status in
  input wire dtp_pkg::dtp_fault_s fault_i,
  input wire logic trip_reset_i,
  input wire logic [7:0] drive_state_i,
  input wire logic [7:0] frequency_source_select_i,
  // trip factor out
  output dtp_pkg::dtp_trip_factor_s trip_factor_o,
  output logic tripped_o,
  // profile values out
  output logic speed_target_valid_o,
  output logic [31:0] speed_target_o,
  output logic [2:0][31:0] accel_time_o,
  output logic [2:0][31:0] decel_time_o,
  output logic [15:0] run_key_routing_o
);

  //////////////////////////////////////////////////////////////////////////////
  // elaboration checks on the parameters
  if (FREQ_LIMIT > dtp_pkg::FREQ_MAX || FREQ_LIMIT == 32'h0000_0000) begin : g_bad_freq
    $error("FREQ_LIMIT must be 1 to 40000");
  end
  if (TIME_LIMIT > dtp_pkg::TIME_MAX || TIME_LIMIT < dtp_pkg::TIME_MIN) begin : g_bad_time
    $error("TIME_LIMIT must be 1 to 360000");
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // address to storage slot; hit low for reserved or unknown words
  function automatic logic [4:0] decode_addr(input logic [15:0] addr);
    logic [4:0] res;
    res = 5'h00;
    case (addr)
      dtp_pkg::ADDR_FREQ_HI: res = {1'b1, dtp_pkg::IDX_FREQ_HI};
      dtp_pkg::ADDR_FREQ_LO: res = {1'b1, dtp_pkg::IDX_FREQ_LO};
      dtp_pkg::ADDR_ACC1_HI: res = {1'b1, dtp_pkg::IDX_ACC1_HI};
      dtp_pkg::ADDR_ACC1_LO: res = {1'b1, dtp_pkg::IDX_ACC1_LO};
      dtp_pkg::ADDR_DEC1_HI: res = {1'b1, dtp_pkg::IDX_DEC1_HI};
      dtp_pkg::ADDR_DEC1_LO: res = {1'b1, dtp_pkg::IDX_DEC1_LO};
      dtp_pkg::ADDR_RUNKEY: res = {1'b1, dtp_pkg::IDX_RUNKEY};
      dtp_pkg::ADDR_ACC2_HI: res = {1'b1, dtp_pkg::IDX_ACC2_HI};
      dtp_pkg::ADDR_ACC2_LO: res = {1'b1, dtp_pkg::IDX_ACC2_LO};
      dtp_pkg::ADDR_DEC2_HI: res = {1'b1, dtp_pkg::IDX_DEC2_HI};
      dtp_pkg::ADDR_DEC2_LO: res = {1'b1, dtp_pkg::IDX_DEC2_LO};
      dtp_pkg::ADDR_ACC3_HI: res = {1'b1, dtp_pkg::IDX_ACC3_HI};
      dtp_pkg::ADDR_ACC3_LO: res = {1'b1, dtp_pkg::IDX_ACC3_LO};
      dtp_pkg::ADDR_DEC3_HI: res = {1'b1, dtp_pkg::IDX_DEC3_HI};
      dtp_pkg::ADDR_DEC3_LO: res = {1'b1, dtp_pkg::IDX_DEC3_LO};
      default: res = 5'h00;
    endcase
    return res;
  endfunction : decode_addr

  // clamp a stored time into range, then coarsen long times
  function automatic logic [31:0] effective_time(input logic [31:0] raw);
    logic [31:0] v;
    v = raw;
    if (v < dtp_pkg::TIME_MIN) begin
      v = dtp_pkg::TIME_MIN;
    end else if (v > TIME_LIMIT) begin
      v = TIME_LIMIT;
    end
    if (v >= dtp_pkg::TIME_COARSE_FROM) begin
      v = v - (v % dtp_pkg::TIME_STEP_COARSE);
    end
    return v;
  endfunction : effective_time

  // join a high and low slot into one 32-bit value
  function automatic logic [31:0] pair_value(input logic [15:0] hi, input logic [15:0] lo);
    return {hi, lo};
  endfunction : pair_value

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] regs [dtp_pkg::NUM_REGS];
  logic [4:0] wr_dec;
  logic [4:0] rd_dec;
  logic code_valid;
  logic [7:0] code;
  logic [31:0] next_freq;
  logic [2:0][3:0] acc_hi_idx;
  logic [2:0][3:0] dec_hi_idx;
  logic [7:0] trip_cause;
  logic [7:0] op_state;

  assign wr_dec = decode_addr(reg_req_i.addr);
  assign rd_dec = wr_dec;
  assign acc_hi_idx = {dtp_pkg::IDX_ACC3_HI, dtp_pkg::IDX_ACC2_HI, dtp_pkg::IDX_ACC1_HI};
  assign dec_hi_idx = {dtp_pkg::IDX_DEC3_HI, dtp_pkg::IDX_DEC2_HI, dtp_pkg::IDX_DEC1_HI};

  //////////////////////////////////////////////////////////////////////////////
  // register storage; writes to reserved words change nothing
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < dtp_pkg::NUM_REGS; i++) begin
        regs[i] <= dtp_pkg::REG_RESET;
      end
    end else if (reg_req_i.wr && wr_dec[4]) begin
      regs[wr_dec[3:0]] <= reg_req_i.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // access answer, one cycle after the request
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rsp_o <= '0;
    end else begin
      reg_rsp_o.ack <= reg_req_i.rd || reg_req_i.wr;
      // reserved words flag an error and read as zero
      reg_rsp_o.err <= (reg_req_i.rd || reg_req_i.wr) && !rd_dec[4];
      if (reg_req_i.rd && rd_dec[4]) begin
        reg_rsp_o.rdata <= regs[rd_dec[3:0]];
      end else begin
        reg_rsp_o.rdata <= 16'h0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // trip cause encoding
  dtp_cause_encoder u_cause_encoder (
    .fault_i(fault_i),
    .code_valid_o(code_valid),
    .code_o(code)
  );

  // first trip is held until reset; a trip in the reset cycle still lands
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trip_cause <= dtp_pkg::CAUSE_NONE;
      tripped_o <= 1'b0;
    end else if (code_valid && (!tripped_o || trip_reset_i)) begin
      trip_cause <= code;
      tripped_o <= 1'b1;
    end else if (trip_reset_i) begin
      trip_cause <= dtp_pkg::CAUSE_NONE;
      tripped_o <= 1'b0;
    end
  end

  // operating state follows the drive; codes past 9 keep the last good one
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_state <= dtp_pkg::ST_RESET;
    end else if (drive_state_i <= dtp_pkg::ST_SERVO_FORCING) begin
      op_state <= drive_state_i;
    end
  end

  // both halves are flops; one driver keeps the packed word legal for every tool
  assign trip_factor_o = {trip_cause, op_state};

  //////////////////////////////////////////////////////////////////////////////
  // frequency target, only offered when the serial command is the source
  always_comb begin
    next_freq = pair_value(regs[dtp_pkg::IDX_FREQ_HI], regs[dtp_pkg::IDX_FREQ_LO]);
    // the two words land separately, so an out-of-range pair is clamped
    if (next_freq > FREQ_LIMIT) begin
      next_freq = FREQ_LIMIT;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      speed_target_o <= 32'h0000_0000;
      speed_target_valid_o <= 1'b0;
    end else begin
      speed_target_o <= next_freq;
      speed_target_valid_o <= (frequency_source_select_i == dtp_pkg::FREQ_SRC_SERIAL);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ramp times of the three motor sets
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accel_time_o <= '0;
      decel_time_o <= '0;
    end else begin
      for (int m = 0; m < 3; m++) begin
        accel_time_o[m] <= effective_time(pair_value(regs[acc_hi_idx[m]], regs[acc_hi_idx[m] + 4'h1]));
        decel_time_o[m] <= effective_time(pair_value(regs[dec_hi_idx[m]], regs[dec_hi_idx[m] + 4'h1]));
      end
    end
  end

  // keypad run key routing word passes through a flop
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_key_routing_o <= dtp_pkg::REG_RESET;
    end else begin
      run_key_routing_o <= regs[dtp_pkg::IDX_RUNKEY];
    end
  end

endmodule : dtp_regs
`default_nettype wire

// ### rtl/dtp_pkg.sv
// shared constants, types and register map of the trip code and profile register bank
//
// Contract
// - trip cause high byte; 0 none, 1-4 overcurrent
// - other trip causes use fixed documented codes
// - sequence program faults report codes 43-45
// - user/expansion faults map to 50s/60s/70s
// - low byte carries drive operating state 0-9
// - target frequency two words, used if serial
// - times from 10000 drop the hundredths digit
// - source select 03 means serial network command
package dtp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // holding register offsets (16-bit word addresses)
  localparam logic [15:0] ADDR_FREQ_HI = 16'h0001;
  localparam logic [15:0] ADDR_FREQ_LO = 16'h0002;
  localparam logic [15:0] ADDR_ACC1_HI = 16'h1103;
  localparam logic [15:0] ADDR_ACC1_LO = 16'h1104;
  localparam logic [15:0] ADDR_DEC1_HI = 16'h1105;
  localparam logic [15:0] ADDR_DEC1_LO = 16'h1106;
  localparam logic [15:0] ADDR_RUNKEY = 16'h1107;
  localparam logic [15:0] ADDR_ACC2_HI = 16'h2103;
  localparam logic [15:0] ADDR_ACC2_LO = 16'h2104;
  localparam logic [15:0] ADDR_DEC2_HI = 16'h2105;
  localparam logic [15:0] ADDR_DEC2_LO = 16'h2106;
  localparam logic [15:0] ADDR_ACC3_HI = 16'h3103;
  localparam logic [15:0] ADDR_ACC3_LO = 16'h3104;
  localparam logic [15:0] ADDR_DEC3_HI = 16'h3105;
  localparam logic [15:0] ADDR_DEC3_LO = 16'h3106;

  // storage slot of each register
  localparam int NUM_REGS = 15;
  localparam logic [3:0] IDX_FREQ_HI = 4'h0;
  localparam logic [3:0] IDX_FREQ_LO = 4'h1;
  localparam logic [3:0] IDX_ACC1_HI = 4'h2;
  localparam logic [3:0] IDX_ACC1_LO = 4'h3;
  localparam logic [3:0] IDX_DEC1_HI = 4'h4;
  localparam logic [3:0] IDX_DEC1_LO = 4'h5;
  localparam logic [3:0] IDX_RUNKEY = 4'h6;
  localparam logic [3:0] IDX_ACC2_HI = 4'h7;
  localparam logic [3:0] IDX_ACC2_LO = 4'h8;
  localparam logic [3:0] IDX_DEC2_HI = 4'h9;
  localparam logic [3:0] IDX_DEC2_LO = 4'hA;
  localparam logic [3:0] IDX_ACC3_HI = 4'hB;
  localparam logic [3:0] IDX_ACC3_LO = 4'hC;
  localparam logic [3:0] IDX_DEC3_HI = 4'hD;
  localparam logic [3:0] IDX_DEC3_LO = 4'hE;

  //////////////////////////////////////////////////////////////////////////////
  // value ranges and resets
  localparam logic [31:0] FREQ_MAX = 32'h0000_9C40;      // 40000 x 0.01 Hz
  localparam logic [31:0] TIME_MIN = 32'h0000_0001;      // 0.01 s
  localparam logic [31:0] TIME_MAX = 32'h0005_7E40;      // 360000 x 0.01 s
  localparam logic [31:0] TIME_COARSE_FROM = 32'h0000_2710; // 10000 = 100.0 s
  localparam logic [31:0] TIME_STEP_COARSE = 32'h0000_000A;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] FREQ_SRC_SERIAL = 8'h03;
  localparam logic [3:0] RANGE_INDEX_MAX = 4'h9;

  //////////////////////////////////////////////////////////////////////////////
  // trip cause codes, fixed ones carry their own value
  typedef enum logic [7:0] {
    CAUSE_NONE = 8'h00,
    CAUSE_OC_CONST = 8'h01,
    CAUSE_OC_DECEL = 8'h02,
    CAUSE_OC_ACCEL = 8'h03,
    CAUSE_OC_OTHER = 8'h04,
    CAUSE_OVERLOAD = 8'h05,
    CAUSE_BRAKE_RES = 8'h06,
    CAUSE_OVERVOLT = 8'h07,
    CAUSE_NVM = 8'h08,
    CAUSE_UNDERVOLT = 8'h09,
    CAUSE_CT = 8'h0A,
    CAUSE_CPU = 8'h0B,
    CAUSE_EXTERNAL = 8'h0C,
    CAUSE_UNATTENDED_START = 8'h0D,
    CAUSE_GROUND = 8'h0E,
    CAUSE_INPUT_OV = 8'h0F,
    CAUSE_POWER_FAIL = 8'h10,
    CAUSE_THERMAL_FAN = 8'h14,
    CAUSE_THERMAL = 8'h15,
    CAUSE_GATE_ARRAY = 8'h17,
    CAUSE_PHASE = 8'h18,
    CAUSE_MAIN_CIRCUIT = 8'h19,
    CAUSE_POWER_SWITCH = 8'h1E,
    CAUSE_THERMISTOR = 8'h23,
    CAUSE_BRAKE = 8'h24,
    CAUSE_ESTOP = 8'h25,
    CAUSE_LOW_SPEED_OL = 8'h26,
    CAUSE_SEQ_INSTR = 8'h2B,
    CAUSE_SEQ_NEST = 8'h2C,
    CAUSE_SEQ_EXEC = 8'h2D,
    CAUSE_SEQ_USER = 8'h32,     // base, plus index 0-9
    CAUSE_EXP1 = 8'h3C,         // base, plus index 0-9
    CAUSE_EXP2 = 8'h46          // base, plus index 0-9
  } dtp_cause_e;

  // drive operating state, low order of the trip factor
  typedef enum logic [7:0] {
    ST_RESET = 8'h00,
    ST_STOP = 8'h01,
    ST_DECEL = 8'h02,
    ST_CONST = 8'h03,
    ST_ACCEL = 8'h04,
    ST_ZERO_REF = 8'h05,
    ST_STARTING = 8'h06,
    ST_DC_BRAKE = 8'h07,
    ST_OL_LIMIT = 8'h08,
    ST_SERVO_FORCING = 8'h09
  } dtp_state_e;

  typedef struct packed {
    logic [7:0] cause;
    logic [7:0] state;
  } dtp_trip_factor_s;

  typedef struct packed {
    logic valid;
    dtp_cause_e kind;
    logic [3:0] index;
  } dtp_fault_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dtp_reg_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } dtp_reg_rsp_s;

endpackage : dtp_pkg

// ### rtl/dtp_cause_encoder.sv
// turns a reported fault kind and index into a trip cause code
`timescale 1ns/100ps
`default_nettype none
module dtp_cause_encoder (
  // fault in
  input wire dtp_pkg::dtp_fault_s fault_i,
  // code out
  output logic code_valid_o,
  output logic [7:0] code_o
);

  //////////////////////////////////////////////////////////////////////////////
  // ranged kinds add the index, fixed kinds pass their own value
  always_comb begin
    code_valid_o = 1'b0;
    code_o = dtp_pkg::CAUSE_NONE;
    case (fault_i.kind)
      dtp_pkg::CAUSE_SEQ_USER, dtp_pkg::CAUSE_EXP1, dtp_pkg::CAUSE_EXP2: begin
        // an index past 9 would alias the next range, so drop it
        code_valid_o = fault_i.valid && (fault_i.index <= dtp_pkg::RANGE_INDEX_MAX);
        code_o = fault_i.kind + {4'h0, fault_i.index};
      end
      dtp_pkg::CAUSE_NONE: begin
        code_valid_o = 1'b0;
        code_o = dtp_pkg::CAUSE_NONE;
      end
      dtp_pkg::CAUSE_OC_CONST, dtp_pkg::CAUSE_OC_DECEL, dtp_pkg::CAUSE_OC_ACCEL,
      dtp_pkg::CAUSE_OC_OTHER: begin
        code_valid_o = fault_i.valid;
        code_o = fault_i.kind;
      end
      dtp_pkg::CAUSE_SEQ_INSTR, dtp_pkg::CAUSE_SEQ_NEST, dtp_pkg::CAUSE_SEQ_EXEC: begin
        code_valid_o = fault_i.valid;
        code_o = fault_i.kind;
      end
      default: begin
        // every other enum member is a fixed code; foreign values are refused
        code_valid_o = fault_i.valid && (fault_i.kind inside {
          dtp_pkg::CAUSE_OVERLOAD, dtp_pkg::CAUSE_BRAKE_RES, dtp_pkg::CAUSE_OVERVOLT,
          dtp_pkg::CAUSE_NVM, dtp_pkg::CAUSE_UNDERVOLT, dtp_pkg::CAUSE_CT, dtp_pkg::CAUSE_CPU,
          dtp_pkg::CAUSE_EXTERNAL, dtp_pkg::CAUSE_UNATTENDED_START, dtp_pkg::CAUSE_GROUND,
          dtp_pkg::CAUSE_INPUT_OV, dtp_pkg::CAUSE_POWER_FAIL, dtp_pkg::CAUSE_THERMAL_FAN,
          dtp_pkg::CAUSE_THERMAL, dtp_pkg::CAUSE_GATE_ARRAY, dtp_pkg::CAUSE_PHASE,
          dtp_pkg::CAUSE_MAIN_CIRCUIT, dtp_pkg::CAUSE_POWER_SWITCH, dtp_pkg::CAUSE_THERMISTOR,
          dtp_pkg::CAUSE_BRAKE, dtp_pkg::CAUSE_ESTOP, dtp_pkg::CAUSE_LOW_SPEED_OL});
        code_o = fault_i.kind;
      end
    endcase
  end

endmodule : dtp_cause_encoder
`default_nettype wire

// ### testbench/dtp_assertions.sv
// concurrent checks on the trip code and profile register bank ports
`timescale 1ns/100ps
`default_nettype none
module dtp_assertions #(
  parameter logic [31:0] FREQ_LIMIT = dtp_pkg::FREQ_MAX
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // watched ports
  input wire dtp_pkg::dtp_reg_req_s reg_req_i,
  input wire dtp_pkg::dtp_reg_rsp_s reg_rsp_o,
  input wire dtp_pkg::dtp_fault_s fault_i,
  input wire logic trip_reset_i,
  input wire logic [7:0] drive_state_i,
  input wire logic [7:0] frequency_source_select_i,
  input wire dtp_pkg::dtp_trip_factor_s trip_factor_o,
  input wire logic tripped_o,
  input wire logic speed_target_valid_o,
  input wire logic [31:0] speed_target_o,
  input wire logic [2:0][31:0] accel_time_o,
  input wire logic [15:0] run_key_routing_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  //////////////////////////////////////////////////////////////////////////////
  // register port and profile outputs
  a_ack_after_req: assert property ((reg_req_i.rd || reg_req_i.wr) |=> reg_rsp_o.ack)
    else $error("ack missing");
  a_runkey_follow: assert property ((reg_req_i.wr && reg_req_i.addr == dtp_pkg::ADDR_RUNKEY)
    |-> ##2 run_key_routing_o == $past(reg_req_i.wdata, 2))
    else $error("run key copy wrong");
  a_freq_clamp: assert property (speed_target_o <= FREQ_LIMIT)
    else $error("speed target over limit");
  a_src_flag: assert property (1'b1 |=> speed_target_valid_o ==
    ($past(frequency_source_select_i) == dtp_pkg::FREQ_SRC_SERIAL))
    else $error("speed valid wrong");
  a_time_coarse: assert property (accel_time_o[0] >= dtp_pkg::TIME_COARSE_FROM
    |-> accel_time_o[0] % 10 == 0)
    else $error("hundredths kept");
  //////////////////////////////////////////////////////////////////////////////
  // trip factor
  a_no_trip_zero: assert property (!tripped_o |-> trip_factor_o.cause == 8'h00)
    else $error("cause without trip");
  a_trip_holds: assert property (tripped_o && !trip_reset_i
    |=> tripped_o && $stable(trip_factor_o.cause))
    else $error("trip not held");
  a_exp1_code: assert property (fault_i.valid && fault_i.kind == dtp_pkg::CAUSE_EXP1 && fault_i.index <= 4'h9
    && !tripped_o |=> trip_factor_o.cause == 8'h3C + $past(fault_i.index))
    else $error("ranged code wrong");
  a_state_copy: assert property (drive_state_i <= 8'h09 |=> trip_factor_o.state == $past(drive_state_i))
    else $error("state not shown");
  a_state_keep: assert property (drive_state_i > 8'h09 |=> $stable(trip_factor_o.state))
    else $error("bad state taken");
  // main scenarios reached
  c_trip: cover property ($rose(tripped_o));
  c_err: cover property (reg_rsp_o.err);
  c_clamp: cover property (speed_target_valid_o && speed_target_o == FREQ_LIMIT);
endmodule : dtp_assertions
bind dtp_regs dtp_assertions #(.FREQ_LIMIT(FREQ_LIMIT)) u_chk (.*);
`default_nettype wire

// ### testbench/dtp_master_model.sv
// network master model issuing holding register reads and writes
`timescale 1ns/100ps
`default_nettype none
module dtp_master_model (
  // clock
  input wire logic core_clk_i,
  // request and answer
  output dtp_pkg::dtp_reg_req_s req_o,
  input wire dtp_pkg::dtp_reg_rsp_s rsp_i
);
  initial req_o = '0;
  // one pulsed request, then a bounded wait; caller enters just after an edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
      output logic [15:0] q, output logic e, output logic ok);
    ok = 1'b0;
    req_o = {!w, w, a, d};
    @(posedge core_clk_i);
    #1;
    // released lines flip so a stale value never looks live
    req_o = {1'b0, 1'b0, ~a, ~d};
    // the answer stands for the cycle after the take, so look while it stands
    for (int i = 0; i < 4 && !ok; i++) begin
      ok = (rsp_i.ack === 1'b1);
      q = rsp_i.rdata;
      e = rsp_i.err;
      if (!ok) begin
        @(posedge core_clk_i);
        #1;
      end
    end
    // one more edge so outputs that follow a stored word have settled
    @(posedge core_clk_i);
    #1;
  endtask : xfer
endmodule : dtp_master_model
`default_nettype wire

// ### testbench/dtp_regs_tb_top.sv
// self-checking bench of the trip code and profile register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin err_count++; $display("[ERR] %0t got %0h exp %0h", $time, g, x); end end
module dtp_regs_tb_top;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  dtp_pkg::dtp_reg_req_s reg_req_i;
  dtp_pkg::dtp_reg_rsp_s reg_rsp_o;
  dtp_pkg::dtp_fault_s fault_i = '0;
  logic trip_reset_i = 1'b0;
  logic [7:0] drive_state_i = 8'h00;
  logic [7:0] frequency_source_select_i = 8'h00;
  dtp_pkg::dtp_trip_factor_s trip_factor_o;
  logic tripped_o;
  logic speed_target_valid_o;
  logic [31:0] speed_target_o;
  logic [2:0][31:0] accel_time_o;
  logic [2:0][31:0] decel_time_o;
  logic [15:0] run_key_routing_o;
  int err_count = 0;
  int cmp_count = 0;
  logic [15:0] rdata;
  logic err;
  logic ok;
  // 200 MHz clock
  always #2.5 core_clk_i = ~core_clk_i;
  //////////////////////////////////////////////////////////////////////////////
  dtp_master_model u_mst (.core_clk_i, .req_o(reg_req_i), .rsp_i(reg_rsp_o));
  dtp_regs u_dut (.core_clk_i, .reset_n_i, .reg_req_i, .reg_rsp_o, .fault_i, .trip_reset_i, .drive_state_i,
    .frequency_source_select_i, .trip_factor_o, .tripped_o, .speed_target_valid_o, .speed_target_o,
    .accel_time_o, .decel_time_o, .run_key_routing_o);
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // one access with expected error flag and read data; outputs settled on return
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e,
      input logic [15:0] x);
    u_mst.xfer(w, a, d, rdata, err, ok);
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t no answer", $time);
      stop_test();
    end
    `CHK(err, e)
    `CHK(rdata, x)
  endtask : acc
  task automatic tick;
    @(posedge core_clk_i);
    #1;
  endtask : tick
  //////////////////////////////////////////////////////////////////////////////
  // reset values, write and read back every word, then reserved places
  task automatic t_regs;
    logic [15:0] map [15] = '{16'h0001, 16'h0002, 16'h1103, 16'h1104, 16'h1105, 16'h1106, 16'h1107,
      16'h2103, 16'h2104, 16'h2105, 16'h2106, 16'h3103, 16'h3104, 16'h3105, 16'h3106};
    for (int i = 0; i < 15; i++) begin
      acc(1'b0, map[i], 16'h0000, 1'b0, 16'h0000);
      acc(1'b1, map[i], 16'h5A00 + 16'(i), 1'b0, 16'h0000);
      acc(1'b0, map[i], 16'h0000, 1'b0, 16'h5A00 + 16'(i));
    end
    `CHK(run_key_routing_o, 16'h5A06)
    acc(1'b0, 16'h2107, 16'h0000, 1'b1, 16'h0000);
    acc(1'b0, 16'h1108, 16'h0000, 1'b1, 16'h0000);
    $display("t_regs done");
  endtask : t_regs
  // frequency pair, clamp and serial source flag
  task automatic t_freq;
    acc(1'b1, 16'h0001, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, 16'h0002, 16'h9C40, 1'b0, 16'h0000);
    `CHK(speed_target_o, 32'h0000_9C40)
    frequency_source_select_i = 8'h03;
    tick();
    `CHK(speed_target_valid_o, 1'b1)
    acc(1'b1, 16'h0002, 16'h9C41, 1'b0, 16'h0000);
    `CHK(speed_target_o, 32'h0000_9C40)
    frequency_source_select_i = 8'h02;
    tick();
    `CHK(speed_target_valid_o, 1'b0)
    $display("t_freq done");
  endtask : t_freq
  // hundredths dropped from 10000 upward, upper clamp
  task automatic t_time;
    acc(1'b1, 16'h1103, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, 16'h1104, 16'h2717, 1'b0, 16'h0000);
    `CHK(accel_time_o[0], 32'h0000_2710)
    acc(1'b1, 16'h1104, 16'h270F, 1'b0, 16'h0000);
    `CHK(accel_time_o[0], 32'h0000_270F)
    acc(1'b1, 16'h2103, 16'h0000, 1'b0, 16'h0000);
    `CHK(accel_time_o[1], 32'h0000_5A00)
    acc(1'b1, 16'h3106, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, 16'h3105, 16'h0006, 1'b0, 16'h0000);
    `CHK(decel_time_o[2], 32'h0005_7E40)
    `CHK(decel_time_o[0], 32'h0005_7E40)
    `CHK(decel_time_o[1], 32'h0005_7E40)
    acc(1'b1, 16'h3103, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, 16'h3104, 16'h0000, 1'b0, 16'h0000);
    `CHK(accel_time_o[2], 32'h0000_0001)
    $display("t_time done");
  endtask : t_time
  // sixteen sample codes latched, a second fault ignored, then cleared
  task automatic t_trip;
    logic [7:0] kd [16] = '{8'h01, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0D, 8'h14, 8'h15, 8'h1E, 8'h25,
      8'h2B, 8'h2C, 8'h2D, 8'h32, 8'h3C, 8'h46};
    logic [3:0] ix;
    for (int i = 0; i < 16; i++) begin
      ix = (kd[i] inside {8'h32, 8'h46}) ? 4'h9 : 4'h0;
      fault_i = {1'b1, dtp_pkg::dtp_cause_e'(kd[i]), ix};
      tick();
      fault_i.kind = dtp_pkg::CAUSE_CPU;
      tick();
      fault_i.valid = 1'b0;
      `CHK(trip_factor_o.cause, kd[i] + ix)
      `CHK(tripped_o, 1'b1)
      trip_reset_i = 1'b1;
      tick();
      trip_reset_i = 1'b0;
      `CHK(trip_factor_o.cause, 8'h00)
    end
    // a new trip in the clearing cycle wins over the clear
    fault_i = {1'b1, dtp_pkg::CAUSE_OVERLOAD, 4'h0};
    tick();
    fault_i = {1'b1, dtp_pkg::CAUSE_EXP2, 4'h3};
    trip_reset_i = 1'b1;
    tick();
    trip_reset_i = 1'b0;
    fault_i.valid = 1'b0;
    `CHK(trip_factor_o.cause, 8'h49)
    `CHK(tripped_o, 1'b1)
    trip_reset_i = 1'b1;
    tick();
    trip_reset_i = 1'b0;
    fault_i = {1'b1, dtp_pkg::CAUSE_EXP1, 4'hA};
    tick();
    fault_i.valid = 1'b0;
    tick();
    `CHK(tripped_o, 1'b0)
    $display("t_trip done");
  endtask : t_trip
  // every operating state shown, an illegal one ignored
  task automatic t_state;
    for (int s = 0; s < 11; s++) begin
      drive_state_i = 8'(s);
      tick();
      `CHK(trip_factor_o.state, (s > 9) ? 8'h09 : 8'(s))
    end
    $display("t_state done");
  endtask : t_state
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk_i);
    #1;
    reset_n_i = 1'b1;
    t_regs();
    t_freq();
    t_time();
    t_trip();
    t_state();
    stop_test();
  end
endmodule : dtp_regs_tb_top
`default_nettype wire
